// [design/dclm_pkg.sv]
// package for the drive current-limit and overload monitor
`default_nettype none
package dclm_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  // 0.1 s time base for the alarm timers: one tick every 0.1 s
  localparam real         TICK_S          = 0.1;
  localparam int unsigned TICK_CYC        = int'(TICK_S * CLK_HZ);
  // 0.01 Hz/s slope units, applied once per tick
  localparam logic [15:0] DROP_SLOPE_RST  = 16'h03e8;   // 10.00 Hz/s
  localparam logic [11:0] CFG_RST         = 12'h000;
  localparam logic [11:0] CFG_MAX         = 12'h131;
  localparam logic [8:0]  OL_LEVEL_HEAVY  = 9'h096;     // 150 %
  localparam logic [8:0]  OL_LEVEL_LIGHT  = 9'h078;     // 120 %
  localparam logic [8:0]  UL_LEVEL_RST    = 9'h032;     // 50 %
  localparam logic [15:0] TIME_RST        = 16'h000a;   // 1.0 s in 0.1 s units
  localparam logic [8:0]  CL_LEVEL_RST    = 9'h0a0;     // 160 %, plain default
  // ones/tens/hundreds digit positions of the config word
  localparam int unsigned DIG_REF         = 0;
  localparam int unsigned DIG_POL         = 4;
  localparam int unsigned DIG_WIN         = 8;

  // APB register byte offsets
  localparam logic [7:0] A_CFG   = 8'h00;
  localparam logic [7:0] A_SLOPE = 8'h04;
  localparam logic [7:0] A_OL_LV = 8'h08;
  localparam logic [7:0] A_OL_T  = 8'h0c;
  localparam logic [7:0] A_UL_LV = 8'h10;
  localparam logic [7:0] A_UL_T  = 8'h14;
  localparam logic [7:0] A_CL_LV = 8'h18;
  localparam logic [7:0] A_STAT  = 8'h1c;
  localparam logic [7:0] A_FREQ  = 8'h20;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dclm_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dclm_apb_rsp_s;

  typedef struct packed {
    logic [15:0] target_freq;   // 0.01 Hz
    logic [15:0] lower_freq;    // 0.01 Hz
    logic [15:0] accel_step;    // 0.01 Hz per tick
    logic [15:0] meas_current;  // amps x10
    logic [15:0] rated_motor;   // amps x10
    logic [15:0] rated_drive;   // amps x10
    logic        run;
  } dclm_drive_s;

  typedef enum logic [1:0] {
    DCLM_ACCEL = 2'b00,
    DCLM_CONST = 2'b01,
    DCLM_HOLD  = 2'b10,
    DCLM_DROP  = 2'b11
  } dclm_mode_e;
endpackage
`default_nettype wire

// [design/dclm_monitor.sv]
// current-limit frequency governor and overload/underload pre-alarm monitor
// What this block does
// - over limit at constant speed: drop at slope
// - below limit again: resume accelerating to target
// - overload pre-alarm after overload time elapses
// - overload level default 150 or 120 percent
// - config word 0x000 to 0x131, reset zero
// - ones digit: motor or drive rated reference
// - tens 0: alarms only, keep running
// - tens 1: fault stop on overload only
// - tens 2: fault stop on underload only
// - tens 3: fault stop on either
// - hundreds digit: always or constant speed only
// - over limit while accelerating: hold frequency
// - underload pre-alarm after underload time, 50 percent
//
// The APB register port and the address map were decided locally.
`default_nettype none
module dclm_monitor #(
  parameter bit          HEAVY_DUTY = 1'b1,
  // cycles per 0.1 s tick; kept as a parameter so a short run can reach the timers
  parameter int unsigned TICK_DIV   = dclm_pkg::TICK_CYC
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire dclm_pkg::dclm_apb_req_s apb_i,
  output var  dclm_pkg::dclm_apb_rsp_s apb_o,
  input  wire dclm_pkg::dclm_drive_s   drive_i,
  output logic [15:0]                 out_freq_o,
  output logic                        overload_alarm_o,
  output logic                        underload_alarm_o,
  output logic                        fault_stop_o
);
  import dclm_pkg::*;

  logic [11:0] cfg;
  logic [15:0] slope;
  logic [8:0]  ol_level;
  logic [15:0] ol_time;
  logic [8:0]  ul_level;
  logic [15:0] ul_time;
  logic [8:0]  cl_level;
  logic [31:0] tick_cnt;
  logic        tick;
  logic [15:0] freq;
  logic [15:0] ol_cnt;
  logic [15:0] ul_cnt;
  logic        ol_alarm;
  logic        ul_alarm;
  logic        fault;
  dclm_mode_e  mode;

  // ---- APB slave: zero wait state
  wire        wr_en   = apb_i.psel & apb_i.penable & apb_i.pwrite;
  wire [11:0] wcfg    = apb_i.pwdata[11:0];
  wire        cfg_ok  = (wcfg <= CFG_MAX) && (wcfg[7:4] <= 4'h3) && (wcfg[3:0] <= 4'h1);
  wire        known   = (apb_i.paddr <= A_FREQ) && (apb_i.paddr[1:0] == 2'b00);
  logic [31:0] rd_mux;
  always_comb begin
    unique case (apb_i.paddr)
      A_CFG:   rd_mux = {20'h0, cfg};
      A_SLOPE: rd_mux = {16'h0, slope};
      A_OL_LV: rd_mux = {23'h0, ol_level};
      A_OL_T:  rd_mux = {16'h0, ol_time};
      A_UL_LV: rd_mux = {23'h0, ul_level};
      A_UL_T:  rd_mux = {16'h0, ul_time};
      A_CL_LV: rd_mux = {23'h0, cl_level};
      A_STAT:  rd_mux = {26'h0, mode, fault, ul_alarm, ol_alarm, drive_i.run};
      A_FREQ:  rd_mux = {16'h0, freq};
      default: rd_mux = 32'h0;
    endcase
  end
  assign apb_o = '{pready: 1'b1, pslverr: apb_i.psel & apb_i.penable & ~known, prdata: rd_mux};

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg      <= CFG_RST;
      slope    <= DROP_SLOPE_RST;
      ol_level <= 9'h000;
      ol_time  <= TIME_RST;
      ul_level <= UL_LEVEL_RST;
      ul_time  <= TIME_RST;
      cl_level <= CL_LEVEL_RST;
    end else if (wr_en) begin
      if (apb_i.paddr == A_CFG && cfg_ok) cfg <= wcfg;
      if (apb_i.paddr == A_SLOPE) slope    <= apb_i.pwdata[15:0];
      if (apb_i.paddr == A_OL_LV) ol_level <= apb_i.pwdata[8:0];
      if (apb_i.paddr == A_OL_T)  ol_time  <= apb_i.pwdata[15:0];
      if (apb_i.paddr == A_UL_LV) ul_level <= apb_i.pwdata[8:0];
      if (apb_i.paddr == A_UL_T)  ul_time  <= apb_i.pwdata[15:0];
      if (apb_i.paddr == A_CL_LV) cl_level <= apb_i.pwdata[8:0];
    end
  end

  // overload level register resets to zero and means "use duty default"
  wire [8:0] ol_eff = (ol_level != 9'h000) ? ol_level :
                      (HEAVY_DUTY ? OL_LEVEL_HEAVY : OL_LEVEL_LIGHT);

  // ---- 0.1 s tick divider
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) tick_cnt <= 32'h0;
    else if (tick) tick_cnt <= 32'h0;
    else tick_cnt <= tick_cnt + 32'h1;
  end
  assign tick = (tick_cnt == 32'(TICK_DIV - 1));

  // ---- current comparisons in percent of the chosen rated current
  wire [15:0] rated   = cfg[DIG_REF] ? drive_i.rated_drive : drive_i.rated_motor;
  function automatic logic above(input logic [15:0] i, input logic [15:0] r, input logic [8:0] pct);
    above = (32'(i) * 32'd100) > (32'(r) * 32'(pct));
  endfunction
  function automatic logic below(input logic [15:0] i, input logic [15:0] r, input logic [8:0] pct);
    below = (32'(i) * 32'd100) < (32'(r) * 32'(pct));
  endfunction
  wire over_cl  = above(drive_i.meas_current, rated, cl_level);
  wire over_ol  = above(drive_i.meas_current, rated, ol_eff);
  wire under_ul = below(drive_i.meas_current, rated, ul_level);

  // ---- frequency governor
  wire at_target = (freq >= drive_i.target_freq);
  wire [16:0] up_sum = {1'b0, freq} + {1'b0, drive_i.accel_step};
  wire [15:0] up_f   = (up_sum[15:0] > drive_i.target_freq || up_sum[16]) ? drive_i.target_freq : up_sum[15:0];
  // slope is per second; one tick is a tenth, so a tenth of the slope per tick
  wire [15:0] drop_s = slope / 16'd10;
  wire [16:0] dn_lim = {1'b0, drive_i.lower_freq} + {1'b0, drop_s};
  wire [15:0] dn_f   = ({1'b0, freq} > dn_lim) ? freq - drop_s : drive_i.lower_freq;
  dclm_mode_e next_mode;
  always_comb begin
    if (!drive_i.run || fault) next_mode = DCLM_CONST;
    // once dropping, keep dropping below target until the current falls back
    else if (over_cl) next_mode = (at_target || mode == DCLM_DROP) ? DCLM_DROP : DCLM_HOLD;
    else next_mode = at_target ? DCLM_CONST : DCLM_ACCEL;
  end

  logic [15:0] next_freq;
  always_comb begin
    next_freq = freq;
    if (!drive_i.run || fault) next_freq = 16'h0;
    else if (tick) begin
      unique case (mode)
        DCLM_ACCEL: next_freq = up_f;
        // a stale const mode right after run rises must not jump to target
        DCLM_CONST: next_freq = at_target ? drive_i.target_freq : freq;
        DCLM_HOLD:  next_freq = freq;
        DCLM_DROP:  next_freq = dn_f;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= DCLM_CONST;
      freq <= 16'h0;
    end else begin
      mode <= next_mode;
      freq <= next_freq;
    end
  end

  // ---- pre-alarm timers, in 0.1 s ticks
  wire det_on = ~cfg[DIG_WIN] | (mode == DCLM_CONST);
  wire ol_cond = over_ol & det_on & drive_i.run;
  wire ul_cond = under_ul & det_on & drive_i.run;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ol_cnt <= 16'h0;
      ul_cnt <= 16'h0;
    end else begin
      if (!ol_cond) ol_cnt <= 16'h0;
      else if (tick && ol_cnt != 16'hffff) ol_cnt <= ol_cnt + 16'h1;
      if (!ul_cond) ul_cnt <= 16'h0;
      else if (tick && ul_cnt != 16'hffff) ul_cnt <= ul_cnt + 16'h1;
    end
  end
  wire next_ol = ol_cond && (ol_cnt > ol_time);
  wire next_ul = ul_cond && (ul_cnt > ul_time);

  // stop policy from the tens digit
  wire [3:0] pol = cfg[DIG_POL +: 4];
  wire stop_ol = (pol == 4'h1) || (pol == 4'h3);
  wire stop_ul = (pol == 4'h2) || (pol == 4'h3);
  // fault latches until run is withdrawn; policy 0 never stops
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ol_alarm <= 1'b0;
      ul_alarm <= 1'b0;
      fault    <= 1'b0;
    end else begin
      ol_alarm <= next_ol;
      ul_alarm <= next_ul;
      if ((next_ol && stop_ol) || (next_ul && stop_ul)) fault <= 1'b1;
      else if (!drive_i.run) fault <= 1'b0;
    end
  end

  assign out_freq_o        = freq;
  assign overload_alarm_o  = ol_alarm;
  assign underload_alarm_o = ul_alarm;
  assign fault_stop_o      = fault;

  // ---- assertions
  // governor
  a_drop_not_rise: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mode == DCLM_DROP && drive_i.run && !fault) |=> (freq <= $past(freq)))
    else $error("frequency rose while dropping");

  a_drop_stays: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mode == DCLM_DROP && drive_i.run && !fault && over_cl) |=> (mode == DCLM_DROP))
    else $error("drop left while still over limit");

  a_freq_floor: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mode == DCLM_DROP && drive_i.run && !fault) |=> (freq >= $past(drive_i.lower_freq)))
    else $error("frequency dropped below lower limit");

  a_hold_freq: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mode == DCLM_HOLD && drive_i.run && !fault && $stable(drive_i.run)) |=> (freq == $past(freq)))
    else $error("frequency changed while held");

  a_hold_over_limit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (drive_i.run && !fault && over_cl && !at_target && mode != DCLM_DROP) |=> (mode == DCLM_HOLD))
    else $error("no hold while accelerating over limit");

  a_resume_accel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (drive_i.run && !fault && !over_cl && !at_target) |=> (mode == DCLM_ACCEL))
    else $error("no resume after current fell");

  a_accel_ceiling: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mode == DCLM_ACCEL && drive_i.run && !fault) |=> (freq <= $past(drive_i.target_freq)))
    else $error("acceleration passed the target");

  // alarm timers
  a_ol_timer_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !ol_cond |=> (ol_cnt == 16'h0))
    else $error("overload timer not restarted");

  a_ul_timer_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !ul_cond |=> (ul_cnt == 16'h0))
    else $error("underload timer not restarted");

  a_ol_alarm_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ol_alarm |-> $past(ol_cond) && ($past(ol_cnt) > $past(ol_time)))
    else $error("overload alarm without elapsed time");

  a_ul_alarm_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ul_alarm |-> $past(ul_cond) && ($past(ul_cnt) > $past(ul_time)))
    else $error("underload alarm without elapsed time");

  a_ol_alarm_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ol_cond && ol_cnt > ol_time) |=> ol_alarm)
    else $error("overload alarm missing after time");

  a_ul_alarm_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ul_cond && ul_cnt > ul_time) |=> ul_alarm)
    else $error("underload alarm missing after time");

  a_ol_default: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ol_level == 9'h000) |-> (ol_eff == (HEAVY_DUTY ? OL_LEVEL_HEAVY : OL_LEVEL_LIGHT)))
    else $error("overload level not the duty default");

  // stop policy and configuration
  a_policy_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (pol == 4'h0 && !fault) |=> !fault)
    else $error("fault under alarm-only policy");

  a_stop_ol: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (next_ol && stop_ol) |=> fault)
    else $error("no stop on overload");

  a_stop_ul: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (next_ul && stop_ul) |=> fault)
    else $error("no stop on underload");

  a_no_stop_ul: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (pol == 4'h1 && !fault && !next_ol) |=> !fault)
    else $error("stop on underload under overload-only policy");

  a_no_stop_ol: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (pol == 4'h2 && !fault && !next_ul) |=> !fault)
    else $error("stop on overload under underload-only policy");

  a_fault_freq_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    fault |=> (freq == 16'h0))
    else $error("output frequency kept after fault stop");

  a_fault_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !drive_i.run |=> !fault)
    else $error("fault kept after run withdrawn");

  a_cfg_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cfg <= CFG_MAX)
    else $error("config word out of range");

  a_window_const: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cfg[DIG_WIN] && mode != DCLM_CONST) |-> !ol_cond && !ul_cond)
    else $error("detection outside constant speed");

  c_drop: cover property (@(posedge sys_clk_i) disable iff (rst_i) mode == DCLM_DROP);
  c_hold: cover property (@(posedge sys_clk_i) disable iff (rst_i) mode == DCLM_HOLD);
  c_ol_alarm: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(ol_alarm));
  c_ul_alarm: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(ul_alarm));
  c_fault: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(fault));
endmodule
`default_nettype wire

// [bench/tb_drive_current_limit_overload_monitor.sv]
// self-checking bench for the current-limit and overload monitor
`default_nettype none
module tb_drive_current_limit_overload_monitor;
  import dclm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic          sys_clk_i;
  logic          rst_i;
  dclm_apb_req_s req;
  dclm_apb_rsp_s rsp;
  dclm_drive_s   drv;
  logic [15:0]   freq;
  logic          ol_alarm;
  logic          ul_alarm;
  logic          fault;
  int            n_errors;
  int            samples_checked;

  // a 20-cycle tick stands in for 0.1 s so the timers run within a short test
  dclm_monitor #(.HEAVY_DUTY(1'b1), .TICK_DIV(20)) dclm_monitor_i (
    .sys_clk_i         (sys_clk_i),
    .rst_i             (rst_i),
    .apb_i             (req),
    .apb_o             (rsp),
    .drive_i           (drv),
    .out_freq_o        (freq),
    .overload_alarm_o  (ol_alarm),
    .underload_alarm_o (ul_alarm),
    .fault_stop_o      (fault)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge sys_clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk_i);
    req.penable <= 1'b1;
    @(posedge sys_clk_i);
    while (rsp.pready !== 1'b1) @(posedge sys_clk_i);
    q   = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, msg);
    chk({31'h0, e}, 32'h0, "read error flag");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic t_reset_values;
    rd_chk(A_CFG, 32'h0, "cfg reset");
    rd_chk(A_SLOPE, {16'h0, DROP_SLOPE_RST}, "slope reset");
    rd_chk(A_OL_LV, 32'h0, "ol level reset");
    rd_chk(A_OL_T, {16'h0, TIME_RST}, "ol time reset");
    rd_chk(A_UL_LV, 32'h32, "ul level reset");
    rd_chk(A_UL_T, {16'h0, TIME_RST}, "ul time reset");
    rd_chk(A_CL_LV, 32'ha0, "cl level reset");
  endtask

  // every legal digit combination is accepted and read back
  task automatic t_cfg_codes;
    logic [11:0] c;
    for (int h = 0; h < 2; h++) begin
      for (int t = 0; t < 4; t++) begin
        for (int o = 0; o < 2; o++) begin
          c = {h[3:0], t[3:0], o[3:0]};
          wr(A_CFG, {20'h0, c});
          rd_chk(A_CFG, {20'h0, c}, "cfg code");
        end
      end
    end
  endtask

  // out-of-range codes leave the last legal value in place
  task automatic t_cfg_refused;
    logic [11:0] bad [4] = '{12'h132, 12'h002, 12'h040, 12'h200};
    wr(A_CFG, 32'h131);
    foreach (bad[i]) begin
      wr(A_CFG, {20'h0, bad[i]});
      rd_chk(A_CFG, 32'h131, "cfg refused");
    end
  endtask

  task automatic t_unmapped;
    logic [31:0] q;
    logic        e;
    apb(1'b1, 8'h24, 32'h1, q, e);
    chk({31'h0, e}, 32'h1, "unmapped write error");
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped read error");
    wr(A_CL_LV, 32'hc8);
    rd_chk(A_CL_LV, 32'hc8, "cl level write");
    wr(A_CL_LV, 32'ha0);
  endtask

  // an overload shorter than the overload time: no alarm, no rise
  task automatic t_overload_short;
    wr(A_CFG, 32'h010);
    drv.meas_current <= 16'd300;
    drv.run          <= 1'b1;
    repeat (100) @(posedge sys_clk_i);
    chk({31'h0, ol_alarm}, 32'h0, "early overload alarm");
    chk({31'h0, fault}, 32'h0, "early fault stop");
    chk({16'h0, freq}, 32'h0, "frequency rose over limit");
    chk({31'h0, ul_alarm}, 32'h0, "underload alarm");
    drv.meas_current <= 16'd0;
    repeat (100) @(posedge sys_clk_i);
    chk({31'h0, ul_alarm}, 32'h0, "early underload alarm");
    idle();
  endtask

  task automatic idle;
    drv.run          <= 1'b0;
    drv.meas_current <= 16'd100;
    repeat (3) @(posedge sys_clk_i);
  endtask

  task automatic expose(input logic [11:0] c, input logic [15:0] m, input int n);
    wr(A_CFG, {20'h0, c});
    drv.meas_current <= m;
    drv.run          <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
  endtask

  // ramp, hold over limit, resume, drop at target down to the floor
  task automatic t_governor;
    logic [15:0] f;
    wr(A_CFG, 32'h000);
    drv.meas_current <= 16'd100;
    drv.run          <= 1'b1;
    repeat (400) @(posedge sys_clk_i);
    drv.meas_current <= 16'd200;
    repeat (2) @(posedge sys_clk_i);
    f = freq;
    chk({31'h0, (f > 16'd0) && (f < drv.target_freq)}, 32'h1, "hold point not mid ramp");
    repeat (200) @(posedge sys_clk_i);
    chk({16'h0, freq}, {16'h0, f}, "frequency moved in hold");
    drv.meas_current <= 16'd100;
    repeat (800) @(posedge sys_clk_i);
    chk({16'h0, freq}, {16'h0, drv.target_freq}, "target not reached");
    drv.meas_current <= 16'd200;
    repeat (1200) @(posedge sys_clk_i);
    chk({16'h0, freq}, {16'h0, drv.lower_freq}, "drop did not reach floor");
    chk({31'h0, ol_alarm}, 32'h1, "overload alarm missing");
    chk({31'h0, fault}, 32'h0, "fault under alarm-only policy");
    drv.meas_current <= 16'd100;
    repeat (3) @(posedge sys_clk_i);
    chk({31'h0, ol_alarm}, 32'h0, "overload alarm kept after break");
    repeat (100) @(posedge sys_clk_i);
    chk({31'h0, freq > drv.lower_freq}, 32'h1, "no resume after drop");
    idle();
  endtask

  // timers, duty default, reference, stop policies and detection window
  task automatic t_alarm_policy;
    expose(12'h000, 16'd200, 180);
    chk({31'h0, ol_alarm}, 32'h0, "overload alarm before time");
    drv.meas_current <= 16'd100;
    repeat (2) @(posedge sys_clk_i);
    drv.meas_current <= 16'd200;
    repeat (180) @(posedge sys_clk_i);
    chk({31'h0, ol_alarm}, 32'h0, "timer kept count over a break");
    repeat (60) @(posedge sys_clk_i);
    chk({31'h0, ol_alarm}, 32'h1, "overload alarm missing");
    chk({31'h0, fault}, 32'h0, "fault under alarm-only policy");
    idle();
    expose(12'h000, 16'd140, 240);
    chk({31'h0, ol_alarm}, 32'h0, "alarm below default level");
    drv.meas_current <= 16'd160;
    repeat (240) @(posedge sys_clk_i);
    chk({31'h0, ol_alarm}, 32'h1, "no alarm above default level");
    idle();
    expose(12'h010, 16'd200, 240);
    chk({31'h0, fault}, 32'h1, "no stop on overload");
    chk({16'h0, freq}, 32'h0, "frequency after fault stop");
    idle();
    chk({31'h0, fault}, 32'h0, "fault kept after run fell");
    expose(12'h010, 16'd20, 240);
    chk({31'h0, ul_alarm}, 32'h1, "underload alarm missing");
    chk({31'h0, fault}, 32'h0, "stop on underload");
    idle();
    expose(12'h020, 16'd200, 240);
    chk({31'h0, ol_alarm}, 32'h1, "overload alarm missing");
    chk({31'h0, fault}, 32'h0, "stop on overload");
    idle();
    expose(12'h020, 16'd20, 240);
    chk({31'h0, fault}, 32'h1, "no stop on underload");
    idle();
    expose(12'h030, 16'd200, 240);
    chk({31'h0, fault}, 32'h1, "no stop on overload");
    idle();
    expose(12'h030, 16'd20, 240);
    chk({31'h0, fault}, 32'h1, "no stop on underload");
    idle();
    expose(12'h001, 16'd200, 240);
    chk({31'h0, ol_alarm}, 32'h0, "reference not drive current");
    drv.meas_current <= 16'd400;
    repeat (240) @(posedge sys_clk_i);
    chk({31'h0, ol_alarm}, 32'h1, "no alarm against drive current");
    idle();
    expose(12'h100, 16'd200, 240);
    chk({31'h0, ol_alarm}, 32'h0, "detection outside constant speed");
    idle();
  endtask

  task automatic results;
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    n_errors        = 0;
    samples_checked = 0;
    rst_i           = 1'b1;
    req             = '0;
    drv             = '{target_freq: 16'd5000, lower_freq: 16'd500, accel_step: 16'd100,
                        meas_current: 16'd0, rated_motor: 16'd100, rated_drive: 16'd200, run: 1'b0};
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk({16'h0, freq}, 32'h0, "freq in reset");
    t_reset_values();
    t_cfg_codes();
    t_cfg_refused();
    t_unmapped();
    t_overload_short();
    t_governor();
    t_alarm_policy();
    results();
  end

  // the sequence needs about 6200 cycles
  initial begin
    #(20000 * 4);
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
